/* File: hw/pcd_gpio.sv */
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pcd_params.svh"

module pcd_gpio
#(
   parameter bit HAS_PORT_D = 1'b1
)
(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output var  logic [31:0]           prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   // Port C pins
   input  wire pcd_pkg::pcd_byte_type pc_pin_in,
   output var  pcd_pkg::pcd_byte_type pc_pin_out,
   output var  pcd_pkg::pcd_byte_type pc_pin_oe,
   // Port D pins
   input  wire pcd_pkg::pcd_byte_type pd_pin_in,
   output var  pcd_pkg::pcd_byte_type pd_pin_out,
   output var  pcd_pkg::pcd_byte_type pd_pin_oe,
   // Peripheral overrides
   input  wire logic [7:0]            periph_force_out,
   input  wire logic [7:0]            periph_force_in,
   input  wire logic                  secondary_osc_on,
   input  wire logic                  ccp_output_mode,
   input  wire logic                  capture_compare_pin,
   input  wire logic                  serial_bit6_active,
   input  wire logic                  serial_bit6_value,
   input  wire logic                  usb_transmitting,
   input  wire logic                  usb_minus_drive,
   input  wire logic                  usb_plus_drive,
   input  wire logic                  usb_xcvr_enable_value,
   // Pin levels and USB status to peripherals
   output var  logic                  timer_count_input,
   output var  logic                  ccp_capture_input,
   output var  logic                  sync_serial_clock,
   output var  logic                  sync_serial_data,
   output var  logic                  ext_xcvr_minus_in,
   output var  logic                  ext_xcvr_plus_in,
   output var  logic                  usb_module_on,
   output var  logic                  usb_onchip_active
);
   import pcd_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   pcd_byte_type     port_c_output_latch;
   pcd_byte_type     port_c_direction;
   pcd_byte_type     port_d_output_latch;
   pcd_byte_type     port_d_direction;
   pcd_byte_type     usb_control;
   pcd_byte_type     usb_configuration;
   pcd_byte_type     pc_sync1;
   pcd_byte_type     pc_sync2;
   pcd_byte_type     pc_sync3;
   pcd_byte_type     pc_level;
   pcd_byte_type     pd_sync1;
   pcd_byte_type     pd_sync2;
   pcd_byte_type     pd_sync3;
   pcd_byte_type     pd_level;
   pcd_usb_mode_type usb_mode;
   pcd_byte_type     next_pc_out;
   pcd_byte_type     next_pc_oe;
   pcd_byte_type     next_pd_out;
   pcd_byte_type     next_pd_oe;
   pcd_byte_type     c_read;
   pcd_byte_type     d_read;
   pcd_byte_type     next_rdata;
   logic             next_err;
   logic             access;
   logic             wr_en;
   logic             usb_read_ok;

   // ---------------------------------------------------------------
   // APB access decode
   // ---------------------------------------------------------------
   // One wait state: the read word is captured while pready is low,
   // so the bus never sees a combinational path from paddr.
   assign access = psel & penable;
   assign wr_en  = access & pready & pwrite & pstrb[0] & ~pslverr;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= access & ~pready;
      end
   end

   always_comb
   begin
      next_rdata = 8'h00;
      next_err   = 1'b0;
      case (paddr)
         `PCD_OFS_C_PIN:
         begin
            next_rdata = c_read;
         end
         `PCD_OFS_C_LATCH:
         begin
            next_rdata = port_c_output_latch;
         end
         `PCD_OFS_C_DIR:
         begin
            next_rdata = port_c_direction;
         end
         `PCD_OFS_USB_CTRL:
         begin
            next_rdata = usb_control;
         end
         `PCD_OFS_USB_CFG:
         begin
            next_rdata = usb_configuration;
         end
         `PCD_OFS_D_PIN:
         begin
            next_rdata = d_read;
            next_err   = ~HAS_PORT_D;
         end
         `PCD_OFS_D_LATCH:
         begin
            next_rdata = HAS_PORT_D ? port_d_output_latch : 8'h00;
            next_err   = ~HAS_PORT_D;
         end
         `PCD_OFS_D_DIR:
         begin
            next_rdata = HAS_PORT_D ? port_d_direction : 8'h00;
            next_err   = ~HAS_PORT_D;
         end
         default:
         begin
            next_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (access && !pready)
      begin
         prdata  <= {24'h00_0000, next_rdata};
         pslverr <= next_err;
      end
      else if (!access)
      begin
         pslverr <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Port C registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_c_output_latch <= `PCD_LATCH_RESET;
      end
      else if (wr_en && (paddr == `PCD_OFS_C_LATCH ||
                         paddr == `PCD_OFS_C_PIN))
      begin
         port_c_output_latch <= pwdata[7:0] & `PCD_C_DIR_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_c_direction <= `PCD_C_DIR_RESET;
      end
      else if (wr_en && paddr == `PCD_OFS_C_DIR)
      begin
         port_c_direction <= pwdata[7:0] & `PCD_C_DIR_MASK;
      end
   end

   // ---------------------------------------------------------------
   // USB control and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         usb_control <= `PCD_USB_RESET;
      end
      else if (wr_en && paddr == `PCD_OFS_USB_CTRL)
      begin
         usb_control <= pwdata[7:0] & `PCD_USB_CTRL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         usb_configuration <= `PCD_USB_RESET;
      end
      else if (wr_en && paddr == `PCD_OFS_USB_CFG)
      begin
         usb_configuration <= pwdata[7:0];
      end
   end

   // The transceiver disable bit selects the external transceiver
   // while the module is on.
   always_comb
   begin
      if (!usb_control[`PCD_BIT_USB_ON])
      begin
         usb_mode = pcd_usb_off_type;
      end
      else if (usb_configuration[`PCD_BIT_XCVR_DIS])
      begin
         usb_mode = pcd_usb_external_type;
      end
      else
      begin
         usb_mode = pcd_usb_onchip_type;
      end
   end

   assign usb_read_ok = ~usb_control[`PCD_BIT_USB_ON] &
                        usb_configuration[`PCD_BIT_XCVR_DIS];

   // ---------------------------------------------------------------
   // Port D registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_d_output_latch <= `PCD_LATCH_RESET;
      end
      else if (HAS_PORT_D && wr_en &&
               (paddr == `PCD_OFS_D_LATCH ||
                paddr == `PCD_OFS_D_PIN))
      begin
         port_d_output_latch <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_d_direction <= `PCD_D_DIR_RESET;
      end
      else if (HAS_PORT_D && wr_en && paddr == `PCD_OFS_D_DIR)
      begin
         port_d_direction <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Pin input synchronisers
   // ---------------------------------------------------------------
   // A level is taken only once the second and third stages agree,
   // which filters a single metastable sample.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc_sync1 <= 8'h00;
         pc_sync2 <= 8'h00;
         pc_sync3 <= 8'h00;
         pd_sync1 <= 8'h00;
         pd_sync2 <= 8'h00;
         pd_sync3 <= 8'h00;
      end
      else
      begin
         pc_sync1 <= pc_pin_in;
         pc_sync2 <= pc_sync1;
         pc_sync3 <= pc_sync2;
         pd_sync1 <= pd_pin_in;
         pd_sync2 <= pd_sync1;
         pd_sync3 <= pd_sync2;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_level
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pc_level[gi] <= 1'b0;
               pd_level[gi] <= 1'b0;
            end
            else
            begin
               if (pc_sync2[gi] == pc_sync3[gi])
               begin
                  pc_level[gi] <= pc_sync3[gi];
               end
               if (pd_sync2[gi] == pd_sync3[gi])
               begin
                  pd_level[gi] <= pd_sync3[gi];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Pin read values
   // ---------------------------------------------------------------
   always_comb
   begin
      c_read = pc_level & `PCD_C_PIN_MASK;
      if (!usb_read_ok)
      begin
         c_read[`PCD_BIT_USB_MINUS] = 1'b0;
         c_read[`PCD_BIT_USB_PLUS]  = 1'b0;
      end
      if (secondary_osc_on)
      begin
         c_read[`PCD_BIT_OSC_OUT] = 1'b0;
         c_read[`PCD_BIT_OSC_IN]  = 1'b0;
      end
      d_read = HAS_PORT_D ? pd_level : 8'h00;
   end

   // ---------------------------------------------------------------
   // Port C drivers
   // ---------------------------------------------------------------
   // Overrides are applied in a fixed order so the last one wins;
   // the stored direction is never touched by them.
   always_comb
   begin
      next_pc_oe  = ~port_c_direction & `PCD_C_DIR_MASK;
      next_pc_out = port_c_output_latch;
      next_pc_oe  = (next_pc_oe | periph_force_out) &
                    ~periph_force_in & `PCD_C_DIR_MASK;
      if (ccp_output_mode && !port_c_direction[`PCD_BIT_CCP])
      begin
         next_pc_out[`PCD_BIT_CCP] = capture_compare_pin;
      end
      if (serial_bit6_active)
      begin
         next_pc_out[`PCD_BIT_SERIAL_TX] = serial_bit6_value;
      end
      if (usb_mode == pcd_usb_external_type)
      begin
         next_pc_oe[`PCD_BIT_XCVR_OE]  = 1'b1;
         next_pc_out[`PCD_BIT_XCVR_OE] = usb_xcvr_enable_value;
      end
      if (secondary_osc_on)
      begin
         next_pc_oe[`PCD_BIT_OSC_OUT]  = 1'b0;
         next_pc_oe[`PCD_BIT_OSC_IN]   = 1'b0;
         next_pc_out[`PCD_BIT_OSC_OUT] = 1'b0;
         next_pc_out[`PCD_BIT_OSC_IN]  = 1'b0;
      end
      if (usb_mode == pcd_usb_onchip_type)
      begin
         next_pc_oe[`PCD_BIT_USB_MINUS]  = usb_transmitting;
         next_pc_oe[`PCD_BIT_USB_PLUS]   = usb_transmitting;
         next_pc_out[`PCD_BIT_USB_MINUS] = usb_minus_drive;
         next_pc_out[`PCD_BIT_USB_PLUS]  = usb_plus_drive;
      end
      else
      begin
         next_pc_oe[`PCD_BIT_USB_MINUS]  = 1'b0;
         next_pc_oe[`PCD_BIT_USB_PLUS]   = 1'b0;
         next_pc_out[`PCD_BIT_USB_MINUS] = 1'b0;
         next_pc_out[`PCD_BIT_USB_PLUS]  = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Port D drivers
   // ---------------------------------------------------------------
   always_comb
   begin
      if (HAS_PORT_D)
      begin
         next_pd_oe  = ~port_d_direction;
         next_pd_out = port_d_output_latch;
      end
      else
      begin
         next_pd_oe  = 8'h00;
         next_pd_out = 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Output flops
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc_pin_out <= 8'h00;
         pc_pin_oe  <= 8'h00;
         pd_pin_out <= 8'h00;
         pd_pin_oe  <= 8'h00;
      end
      else
      begin
         pc_pin_out <= next_pc_out;
         pc_pin_oe  <= next_pc_oe;
         pd_pin_out <= next_pd_out;
         pd_pin_oe  <= next_pd_oe;
      end
   end

   // Receive inputs stay live whatever the software direction is;
   // bit 7 serial receive relies on software leaving it an input.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_count_input <= 1'b0;
         ccp_capture_input <= 1'b0;
         sync_serial_clock <= 1'b0;
         sync_serial_data  <= 1'b0;
         ext_xcvr_minus_in <= 1'b0;
         ext_xcvr_plus_in  <= 1'b0;
         usb_module_on     <= 1'b0;
         usb_onchip_active <= 1'b0;
      end
      else
      begin
         timer_count_input <= pc_level[0];
         ccp_capture_input <= pc_level[`PCD_BIT_CCP];
         sync_serial_clock <= pc_level[`PCD_BIT_SERIAL_TX];
         sync_serial_data  <= pc_level[7];
         ext_xcvr_minus_in <= pc_level[`PCD_BIT_USB_MINUS];
         ext_xcvr_plus_in  <= pc_level[`PCD_BIT_USB_PLUS];
         usb_module_on     <= usb_control[`PCD_BIT_USB_ON];
         usb_onchip_active <= (usb_mode == pcd_usb_onchip_type);
      end
   end

endmodule

`default_nettype wire

/* File: hw/pcd_params.svh */
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH

`define PCD_OFS_C_PIN     8'h00
`define PCD_OFS_C_LATCH   8'h04
`define PCD_OFS_C_DIR     8'h08
`define PCD_OFS_USB_CTRL  8'h0C
`define PCD_OFS_USB_CFG   8'h10
`define PCD_OFS_D_PIN     8'h14
`define PCD_OFS_D_LATCH   8'h18
`define PCD_OFS_D_DIR     8'h1C

`define PCD_C_DIR_MASK    8'hC7
`define PCD_C_PIN_MASK    8'hF7
`define PCD_USB_CTRL_MASK 8'h7E
`define PCD_C_DIR_RESET   8'hC7
`define PCD_D_DIR_RESET   8'hFF
`define PCD_LATCH_RESET   8'h00
`define PCD_USB_RESET     8'h00

`define PCD_BIT_OSC_OUT   0
`define PCD_BIT_OSC_IN    1
`define PCD_BIT_XCVR_OE   1
`define PCD_BIT_CCP       2
`define PCD_BIT_USB_MINUS 4
`define PCD_BIT_USB_PLUS  5
`define PCD_BIT_SERIAL_TX 6
`define PCD_BIT_USB_ON    3
`define PCD_BIT_XCVR_DIS  3

`endif

/* File: hw/pcd_pkg.sv */
package pcd_pkg;

   typedef logic [7:0] pcd_byte_type;

   typedef enum logic [1:0]
   {
      pcd_usb_off_type      = 2'b00,
      pcd_usb_onchip_type   = 2'b01,
      pcd_usb_external_type = 2'b10
   } pcd_usb_mode_type;

endpackage

/* File: test/pcd_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pcd_pin_model
(
   // Device pin drive
   input  wire pcd_pkg::pcd_byte_type pc_pin_out,
   input  wire pcd_pkg::pcd_byte_type pc_pin_oe,
   input  wire pcd_pkg::pcd_byte_type pd_pin_out,
   input  wire pcd_pkg::pcd_byte_type pd_pin_oe,
   // Levels of the outside circuitry
   input  wire pcd_pkg::pcd_byte_type pc_ext,
   input  wire pcd_pkg::pcd_byte_type pd_ext,
   // Resolved pin levels
   output var  pcd_pkg::pcd_byte_type pc_pin_in,
   output var  pcd_pkg::pcd_byte_type pd_pin_in
);
   import pcd_pkg::*;

   // The outside circuitry always holds a level, so a released pin never
   // floats; where the device drives, its value wins.
   always_comb
   begin
      pc_pin_in = (pc_pin_oe & pc_pin_out) | (~pc_pin_oe & pc_ext);
      pd_pin_in = (pd_pin_oe & pd_pin_out) | (~pd_pin_oe & pd_ext);
   end
endmodule

`default_nettype wire

/* File: test/pcd_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module pcd_checker
(
   // Clock, reset and bus
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pready,
   // Port C pins
   input  wire pcd_pkg::pcd_byte_type pc_pin_out,
   input  wire pcd_pkg::pcd_byte_type pc_pin_oe,
   // Overrides and status
   input  wire logic [7:0]            periph_force_in,
   input  wire logic                  secondary_osc_on,
   input  wire logic                  ccp_output_mode,
   input  wire logic                  capture_compare_pin,
   input  wire logic [7:0]            periph_force_out,
   input  wire logic                  serial_bit6_active,
   input  wire logic                  serial_bit6_value,
   input  wire logic                  usb_transmitting,
   input  wire logic                  usb_xcvr_enable_value,
   input  wire logic                  usb_module_on,
   input  wire logic                  usb_onchip_active
);
   import pcd_pkg::*;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence first_access;
      psel && $rose(penable);
   endsequence

   sequence ccp_held;
      (ccp_output_mode && !periph_force_out[2] && !periph_force_in[2])
      ##1 (ccp_output_mode && $stable(capture_compare_pin) && pc_pin_oe[2]);
   endsequence

   apb_wait_a: assert property (first_access |-> !pready ##1 pready)
      else $error("bus answer not after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   bit3_idle_a: assert property (!pc_pin_oe[3])
      else $error("absent port C bit 3 driven");
   usb_off_a: assert property (
      !usb_onchip_active [*3] |-> pc_pin_oe[5:4] == 2'b00)
      else $error("bits 4 and 5 driven outside on-chip mode");
   onchip_dir_a: assert property (
      (usb_onchip_active && $stable(usb_transmitting)) [*3]
      |-> pc_pin_oe[5:4] == {2{usb_transmitting}})
      else $error("bits 4 and 5 direction not from USB activity");
   xcvr_enable_a: assert property (
      (usb_module_on && !usb_onchip_active && !secondary_osc_on
       && $stable(usb_xcvr_enable_value)) [*3]
      |-> pc_pin_oe[1] && pc_pin_out[1] == usb_xcvr_enable_value)
      else $error("transceiver enable not on bit 1");
   osc_off_a: assert property (
      secondary_osc_on [*2] |-> pc_pin_oe[1:0] == 2'b00)
      else $error("bits 0 and 1 driven with oscillator on");
   ccp_wins_a: assert property (
      ccp_held |-> pc_pin_out[2] == capture_compare_pin)
      else $error("compare output lost on bit 2");
   serial_wins_a: assert property (
      serial_bit6_active ##1 (serial_bit6_active && pc_pin_oe[6]
      && $stable(serial_bit6_value)) |-> pc_pin_out[6] == serial_bit6_value)
      else $error("serial output lost on bit 6");
   force_in_a: assert property (
      (pc_pin_oe & $past(periph_force_in) & 8'hC5) == 8'h00)
      else $error("forced input pin still driven");
endmodule

bind pcd_gpio pcd_checker pcd_checker_inst
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pc_pin_out(pc_pin_out), .pc_pin_oe(pc_pin_oe),
   .periph_force_in(periph_force_in), .secondary_osc_on(secondary_osc_on),
   .ccp_output_mode(ccp_output_mode),
   .capture_compare_pin(capture_compare_pin),
   .periph_force_out(periph_force_out),
   .serial_bit6_active(serial_bit6_active),
   .serial_bit6_value(serial_bit6_value),
   .usb_transmitting(usb_transmitting),
   .usb_xcvr_enable_value(usb_xcvr_enable_value),
   .usb_module_on(usb_module_on), .usb_onchip_active(usb_onchip_active)
);

`default_nettype wire

/* File: test/pcd_gpio_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pcd_params.svh"

module pcd_gpio_tb;
   import pcd_pkg::*;

   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]   paddr, pfo, pfi, flt;
   logic [31:0]  pwdata, prdata, rdat;
   logic [3:0]   pstrb;
   logic         rerr, osc, ccpm, ccpp, sact, sval, utx, um, up, uxe;
   pcd_byte_type pci, pco, pcoe, pdi, pdo, pdoe, pce, pde;
   int           mismatches = 0;
   int           compares = 0;
   int           cyc = 0;

   pcd_gpio #(.HAS_PORT_D(1'b1)) pcd_gpio_inst
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pc_pin_in(pci), .pc_pin_out(pco), .pc_pin_oe(pcoe),
      .pd_pin_in(pdi), .pd_pin_out(pdo), .pd_pin_oe(pdoe),
      .periph_force_out(pfo), .periph_force_in(pfi),
      .secondary_osc_on(osc), .ccp_output_mode(ccpm),
      .capture_compare_pin(ccpp), .serial_bit6_active(sact),
      .serial_bit6_value(sval), .usb_transmitting(utx),
      .usb_minus_drive(um), .usb_plus_drive(up),
      .usb_xcvr_enable_value(uxe), .timer_count_input(flt[0]),
      .ccp_capture_input(flt[1]), .sync_serial_clock(flt[2]),
      .sync_serial_data(flt[3]), .ext_xcvr_minus_in(flt[4]),
      .ext_xcvr_plus_in(flt[5]), .usb_module_on(flt[6]),
      .usb_onchip_active(flt[7])
   );

   pcd_pin_model pcd_pin_model_inst
   (
      .pc_pin_out(pco), .pc_pin_oe(pcoe), .pd_pin_out(pdo),
      .pd_pin_oe(pdoe), .pc_ext(pce), .pd_ext(pde),
      .pc_pin_in(pci), .pd_pin_in(pdi)
   );

   // ------------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // The run needs a few hundred cycles; the ceiling leaves wide margin.
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One access; an idle cycle follows so no strobe is set twice at once.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pfo, pfi} = '0;
      {osc, ccpm, ccpp, sact, sval, utx, um, up, uxe} = '0;
      pstrb = 4'hF;
      pce = 8'hBD;
      pde = 8'hA5;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(pcoe, 8'h00);
      chk(pdoe, 8'h00);
      rd(`PCD_OFS_C_DIR, 32'hC7);
      rd(`PCD_OFS_D_DIR, 32'hFF);
      rd(`PCD_OFS_USB_CTRL, 32'h00);
      wr(`PCD_OFS_C_LATCH, 32'hFF);
      rd(`PCD_OFS_C_LATCH, 32'hC7);
      wr(`PCD_OFS_C_DIR, 32'hFF);
      rd(`PCD_OFS_C_DIR, 32'hC7);
      wr(`PCD_OFS_C_PIN, 32'h5A);
      rd(`PCD_OFS_C_LATCH, 32'h42);
      repeat (8) @(posedge pclk);
      chk(pcoe, 8'h00);
      rd(`PCD_OFS_C_PIN, 32'h85);
      chk(flt, 8'h3B);
      wr(`PCD_OFS_C_DIR, 32'h00);
      repeat (2) @(posedge pclk);
      chk(pcoe, 8'hC7);
      chk(pco & 8'hC7, 8'h42);
      repeat (8) @(posedge pclk);
      rd(`PCD_OFS_C_PIN, 32'h42);
      wr(`PCD_OFS_USB_CFG, 32'h08);
      repeat (8) @(posedge pclk);
      rd(`PCD_OFS_C_PIN, 32'h72);
      uxe <= 1'b1;
      wr(`PCD_OFS_USB_CTRL, 32'hFF);
      rd(`PCD_OFS_USB_CTRL, 32'h7E);
      chk(pcoe[5:4], 2'b00);
      chk({pcoe[1], pco[1]}, 2'b11);
      chk(flt[7:4], 4'b0111);
      rd(`PCD_OFS_C_PIN, 32'h42);
      wr(`PCD_OFS_USB_CFG, 32'h00);
      utx <= 1'b1;
      um <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(pcoe[5:4], 2'b11);
      chk(pco[5:4], 2'b01);
      chk(flt[7:6], 2'b11);
      utx <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(pcoe[5:4], 2'b00);
      wr(`PCD_OFS_USB_CTRL, 32'h00);
      {pfi, osc, ccpm, ccpp, sact} <= {8'h80, 4'hF};
      repeat (4) @(posedge pclk);
      chk(pcoe, 8'h44);
      chk(pco & 8'h47, 8'h04);
      rd(`PCD_OFS_C_DIR, 32'h00);
      {pfi, osc, ccpm, ccpp, sact} <= '0;
      pfo <= 8'h04;
      wr(`PCD_OFS_C_DIR, 32'hC7);
      repeat (2) @(posedge pclk);
      chk(pcoe, 8'h04);
      pfo <= 8'h00;
      wr(`PCD_OFS_D_DIR, 32'h00);
      wr(`PCD_OFS_D_LATCH, 32'h3C);
      repeat (8) @(posedge pclk);
      chk(pdoe, 8'hFF);
      chk(pdo, 8'h3C);
      rd(`PCD_OFS_D_PIN, 32'h3C);
      wr(`PCD_OFS_D_DIR, 32'hFF);
      repeat (8) @(posedge pclk);
      chk(pdoe, 8'h00);
      rd(`PCD_OFS_D_PIN, 32'hA5);
      rd(`PCD_OFS_D_LATCH, 32'h3C);
      pstrb <= 4'h0;
      wr(`PCD_OFS_D_LATCH, 32'h11);
      pstrb <= 4'hF;
      wr(8'h20, 32'hFF);
      chk(rerr, 1'b1);
      rd(8'h20, 32'h00);
      chk(rerr, 1'b1);
      rd(`PCD_OFS_D_LATCH, 32'h3C);
      wr(`PCD_OFS_D_PIN, 32'h66);
      rd(`PCD_OFS_D_LATCH, 32'h66);
      wr(`PCD_OFS_D_DIR, 32'h00);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(pdoe, 8'h00);
      rd(`PCD_OFS_D_DIR, 32'hFF);
      results();
   end
endmodule

`default_nettype wire
